// >>> src/ebm_fifo_params.svh
// Sizes and reset values for the block memory FIFO
`ifndef EBM_FIFO_PARAMS_SVH
`define EBM_FIFO_PARAMS_SVH

// Address width N and data width of each port
`define EBM_ADDR_W 4
`define EBM_DATA_W 8
// Number of words held by the memory, two to the N
`define EBM_DEPTH 16
// Output latch value after any latch clear
`define EBM_DOUT_RST 8'h00
// Pointer value after a global clear or a rewind
`define EBM_PTR_RST 5'h00

`endif

// >>> src/ebm_fifo_pkg.sv
// Types shared by the block memory FIFO and its users
package ebm_fifo_pkg;

    // Output behaviour of port A on a write cycle
    typedef enum logic [1:0] {
        WM_NORMAL,
        WM_THROUGH,
        WM_READ_FIRST
    } write_mode_type;

endpackage

// >>> src/dual_clock_block_ram_fifo.sv
// Embedded block memory as RAM or as a FIFO with independent port strobes
// How it works
// RULE1 - In normal mode a port A write leaves the port A output unchanged.
// RULE2 - In write-through mode port A shows the word being written.
// RULE3 - In read-before-write mode port A shows the word the address held.
// RULE4 - Writes are taken on a write clock edge with clock enable and enable.
// RULE5 - Reads are taken on a read clock edge with clock enable and strobe.
// RULE6 - Full, almost full, empty and almost empty are made inside the block.
// RULE7 - Full and almost full change only on write clock edges.
// RULE8 - Empty and almost empty change only on read clock edges.
// RULE9 - Full spans 1 to 2^N-1, the almost flags 1 to full-1, empty is 0.
// RULE10 - The global FIFO clear resets both pointers and all flags.
// RULE11 - The rewind resets only the read pointer so data can be re-sent.
// RULE12 - The user tracks packet boundaries when rewinding.
// RULE13 - Output latch clears act synchronously or asynchronously by choice.
// RULE14 - Each port latch clear touches only its own port output.
// RULE15 - The active-low chip-wide reset clears both port outputs.
// RULE16 - Each flag is set while the level is at or beyond its threshold.
`timescale 1ns/10ps
`include "ebm_fifo_params.svh"

module dual_clock_block_ram_fifo (
    // System clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Configuration
    input wire logic fifo_select,
    input ebm_fifo_pkg::write_mode_type write_mode,
    input wire logic latch_reset_sync,
    input wire logic [`EBM_ADDR_W-1:0] full_threshold,
    input wire logic [`EBM_ADDR_W-1:0] almost_full_threshold,
    input wire logic [`EBM_ADDR_W-1:0] almost_empty_threshold,
    // Write side, port A
    input wire logic write_side_clock,
    input wire logic write_clock_enable,
    input wire logic write_enable,
    input wire logic [`EBM_ADDR_W-1:0] addr_a,
    input wire logic [`EBM_DATA_W-1:0] wdata_a,
    output logic [`EBM_DATA_W-1:0] dout_a,
    // Read side, port B
    input wire logic read_side_clock,
    input wire logic read_clock_enable,
    input wire logic read_strobe,
    input wire logic [`EBM_ADDR_W-1:0] addr_b,
    output logic [`EBM_DATA_W-1:0] dout_b,
    // FIFO control and flags
    input wire logic fifo_clear,
    input wire logic read_pointer_rewind,
    output logic full_flag,
    output logic almost_full_flag,
    output logic empty_flag,
    output logic almost_empty_flag,
    // Latch clears
    input wire logic port_a_latch_clear,
    input wire logic port_b_latch_clear,
    input wire logic chip_wide_reset_n
);
    import ebm_fifo_pkg::*;

    localparam int AW = `EBM_ADDR_W;
    localparam int DW = `EBM_DATA_W;

    logic [DW-1:0] mem_ff [`EBM_DEPTH];
    logic wclk_q_ff, rclk_q_ff;
    logic [AW:0] wr_ptr_ff, rd_ptr_ff, nxt_wr_ptr, nxt_rd_ptr;
    logic [DW-1:0] dout_a_ff, dout_b_ff, nxt_dout_a, nxt_dout_b;
    logic full_ff, afull_ff, empty_ff, aempty_ff;
    logic nxt_full, nxt_afull, nxt_empty, nxt_aempty;
    logic wr_edge, rd_edge, a_access, a_write, b_read;
    logic clr_a, clr_b;
    logic [AW:0] level, nxt_level;
    logic [AW-1:0] a_addr, b_addr;
    logic [DW-1:0] a_old_word;

    // Threshold compare, used for both write-side flags, the almost empty flag and the guard
    function automatic logic at_or_above(input logic [AW:0] lvl,
                                         input logic [AW-1:0] thr);
        at_or_above = lvl >= {1'b0, thr};
    endfunction

    // ******************************************************
    // Strobe decode
    // ******************************************************
    // Port clocks are sampled pins; a rising edge is one access slot
    assign wr_edge = write_side_clock & ~wclk_q_ff;
    assign rd_edge = read_side_clock & ~rclk_q_ff;
    assign level = wr_ptr_ff - rd_ptr_ff;
    assign a_addr = fifo_select ? wr_ptr_ff[AW-1:0] : addr_a;
    assign b_addr = fifo_select ? rd_ptr_ff[AW-1:0] : addr_b;
    assign a_old_word = mem_ff[a_addr];
    // A refused FIFO write is no access at all, so port A holds
    assign a_access = wr_edge & write_clock_enable &
                      (~fifo_select | ~write_enable |
                       ~at_or_above(level, full_threshold)); // RULE4
    assign a_write = a_access & write_enable; // RULE4
    assign b_read = rd_edge & read_clock_enable & read_strobe &
                    (~fifo_select | (level != '0)); // RULE5
    assign clr_a = port_a_latch_clear | ~chip_wide_reset_n; // RULE14 RULE15
    assign clr_b = port_b_latch_clear | ~chip_wide_reset_n; // RULE14 RULE15

    // ******************************************************
    // Next state
    // ******************************************************
    // Pointers, output latches and flags
    always_comb begin
        nxt_wr_ptr = wr_ptr_ff;
        nxt_rd_ptr = rd_ptr_ff;
        nxt_dout_a = dout_a_ff;
        nxt_dout_b = dout_b_ff;
        if (fifo_select && a_write) begin
            nxt_wr_ptr = wr_ptr_ff + 1'b1; // RULE4
        end
        if (fifo_select && b_read) begin
            nxt_rd_ptr = rd_ptr_ff + 1'b1; // RULE5
        end
        if (read_pointer_rewind) begin
            nxt_rd_ptr = `EBM_PTR_RST; // RULE11
        end
        if (fifo_clear) begin
            nxt_wr_ptr = `EBM_PTR_RST; // RULE10
            nxt_rd_ptr = `EBM_PTR_RST; // RULE10
        end
        if (a_access) begin
            if (!write_enable) begin
                nxt_dout_a = a_old_word;
            end else begin
                unique case (write_mode)
                    WM_NORMAL: nxt_dout_a = dout_a_ff; // RULE1
                    WM_THROUGH: nxt_dout_a = wdata_a; // RULE2
                    WM_READ_FIRST: nxt_dout_a = a_old_word; // RULE3
                    default: nxt_dout_a = dout_a_ff;
                endcase
            end
        end
        if (b_read) begin
            nxt_dout_b = mem_ff[b_addr]; // RULE5
        end
        // A clear beats an access in the same slot
        if (clr_a) begin
            nxt_dout_a = `EBM_DOUT_RST; // RULE13 RULE14
        end
        if (clr_b) begin
            nxt_dout_b = `EBM_DOUT_RST; // RULE13 RULE14
        end
        nxt_level = nxt_wr_ptr - nxt_rd_ptr;
        nxt_full = full_ff;
        nxt_afull = afull_ff;
        nxt_empty = empty_ff;
        nxt_aempty = aempty_ff;
        // Flags look at the level after this slot's access
        if (wr_edge) begin
            nxt_full = at_or_above(nxt_level, full_threshold); // RULE7 RULE16
            nxt_afull = at_or_above(nxt_level,
                                    almost_full_threshold); // RULE7 RULE16
        end
        if (rd_edge) begin
            nxt_empty = nxt_level == '0; // RULE8 RULE9
            nxt_aempty = ~at_or_above(nxt_level,
                almost_empty_threshold + 1'b1); // RULE8 RULE16
        end
        if (fifo_clear) begin
            nxt_full = 1'b0; // RULE10
            nxt_afull = 1'b0; // RULE10
            nxt_empty = 1'b1; // RULE10
            nxt_aempty = 1'b1; // RULE10
        end
    end

    // Register stage; flags start in their empty state
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wclk_q_ff <= 1'b0;
            rclk_q_ff <= 1'b0;
            wr_ptr_ff <= `EBM_PTR_RST;
            rd_ptr_ff <= `EBM_PTR_RST;
            dout_a_ff <= `EBM_DOUT_RST;
            dout_b_ff <= `EBM_DOUT_RST;
            full_ff <= 1'b0;
            afull_ff <= 1'b0;
            empty_ff <= 1'b1;
            aempty_ff <= 1'b1;
        end else begin
            wclk_q_ff <= write_side_clock;
            rclk_q_ff <= read_side_clock;
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            dout_a_ff <= nxt_dout_a;
            dout_b_ff <= nxt_dout_b;
            full_ff <= nxt_full;
            afull_ff <= nxt_afull;
            empty_ff <= nxt_empty;
            aempty_ff <= nxt_aempty;
        end
    end

    // Array has no reset, as block memory contents never do
    always_ff @(posedge clk_sys) begin
        if (a_write) begin
            mem_ff[a_addr] <= wdata_a; // RULE4
        end
    end

    // ******************************************************
    // Outputs
    // ******************************************************
    // Async mode blanks at once; the flop still clears on the next edge
    assign dout_a = (clr_a & ~latch_reset_sync) ? `EBM_DOUT_RST
                                                : dout_a_ff; // RULE13
    assign dout_b = (clr_b & ~latch_reset_sync) ? `EBM_DOUT_RST
                                                : dout_b_ff; // RULE13
    assign full_flag = full_ff; // RULE6
    assign almost_full_flag = afull_ff; // RULE6
    assign empty_flag = empty_ff; // RULE6
    assign almost_empty_flag = aempty_ff; // RULE6

    // ******************************************************
    // Checks
    // ******************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_normal_hold: assert property ( // RULE1
        a_write && write_mode == WM_NORMAL && !clr_a |=> $stable(dout_a_ff))
        else $error("normal write changed port A output");
    chk_through_copy: assert property ( // RULE2
        a_write && write_mode == WM_THROUGH && !clr_a
        |=> dout_a_ff == $past(wdata_a))
        else $error("write-through output mismatch");
    chk_read_first: assert property ( // RULE3
        a_write && write_mode == WM_READ_FIRST && !clr_a
        |=> dout_a_ff == $past(a_old_word))
        else $error("read-before-write output mismatch");
    chk_write_step: assert property ( // RULE4
        fifo_select && a_write && !fifo_clear
        |=> wr_ptr_ff == $past(wr_ptr_ff) + 1'b1)
        else $error("accepted write did not advance");
    chk_read_data: assert property ( // RULE5
        b_read && !clr_b |=> dout_b_ff == $past(mem_ff[b_addr]))
        else $error("read data mismatch");
    chk_wflag_quiet: assert property ( // RULE7
        !wr_edge && !fifo_clear |=> $stable(full_ff) && $stable(afull_ff))
        else $error("write flags moved without write edge");
    chk_rflag_quiet: assert property ( // RULE8
        !rd_edge && !fifo_clear |=> $stable(empty_ff) && $stable(aempty_ff))
        else $error("read flags moved without read edge");
    chk_empty_level: assert property ( // RULE9
        rd_edge && !fifo_clear |=> empty_ff == (level == '0))
        else $error("empty flag disagrees with level");
    chk_clear_all: assert property ( // RULE10
        fifo_clear |=> level == '0 && empty_ff && aempty_ff && !full_ff &&
        !afull_ff)
        else $error("global clear incomplete");
    chk_rewind_only: assert property ( // RULE11
        read_pointer_rewind && !fifo_clear && !a_write
        |=> rd_ptr_ff == '0 && $stable(wr_ptr_ff))
        else $error("rewind disturbed write pointer");
    chk_async_blank: assert property ( // RULE13
        clr_a && !latch_reset_sync |-> dout_a == '0)
        else $error("async latch clear not immediate");
    chk_port_isolate: assert property ( // RULE14
        port_a_latch_clear && chip_wide_reset_n && !b_read && !clr_b
        |=> dout_a_ff == '0 && $stable(dout_b_ff))
        else $error("port A clear leaked to port B");
    chk_chip_reset: assert property ( // RULE15
        !chip_wide_reset_n |=> dout_a_ff == '0 && dout_b_ff == '0)
        else $error("chip reset left a latch set");
    chk_full_thresh: assert property ( // RULE16
        wr_edge && !fifo_clear
        |=> full_ff == ({1'b0, full_threshold} <= level))
        else $error("full flag disagrees with threshold");

    cov_fifo_full: cover property (fifo_select && full_ff);
    cov_rewind_read: cover property (read_pointer_rewind ##[1:50] b_read);
    cov_read_first: cover property (a_write && write_mode == WM_READ_FIRST);
    cov_async_clear: cover property (clr_b && !latch_reset_sync);

endmodule

// >>> test/ebm_user_model.sv
// User core logic model that drives the FIFO write and read ports
`timescale 1ns/10ps
`include "ebm_fifo_params.svh"

module ebm_user_model (
    // Clock
    input wire logic clk_sys,
    // Write port
    output logic write_side_clock,
    output logic write_clock_enable,
    output logic write_enable,
    output logic [`EBM_ADDR_W-1:0] addr_a,
    output logic [`EBM_DATA_W-1:0] wdata_a,
    // Read port
    output logic read_side_clock,
    output logic read_clock_enable,
    output logic read_strobe,
    output logic [`EBM_ADDR_W-1:0] addr_b
);
    // Idle values; port clocks rest low so reset release sees no edge
    initial begin
        {write_side_clock, write_clock_enable, write_enable} = 3'h0;
        {read_side_clock, read_clock_enable, read_strobe} = 3'h0;
        addr_a = '0;
        addr_b = '0;
        wdata_a = '0;
    end

    // One write slot: port clock high for one cycle, then low
    task automatic wr(input logic [`EBM_ADDR_W-1:0] a,
                      input logic [`EBM_DATA_W-1:0] d, input logic en);
        @(negedge clk_sys);
        write_side_clock = 1'b1;
        write_clock_enable = 1'b1;
        write_enable = en;
        addr_a = a;
        wdata_a = d;
        @(negedge clk_sys);
        write_side_clock = 1'b0;
        write_clock_enable = 1'b0;
        wdata_a = ~d; // Released data must not keep its last value
    endtask

    // One read slot; ce low only ticks the read clock to refresh flags
    task automatic rd(input logic [`EBM_ADDR_W-1:0] a, input logic ce);
        @(negedge clk_sys);
        read_side_clock = 1'b1;
        read_clock_enable = ce;
        read_strobe = ce;
        addr_b = a;
        @(negedge clk_sys);
        read_side_clock = 1'b0;
        read_clock_enable = 1'b0;
        read_strobe = 1'b0;
        addr_b = ~a;
    endtask
endmodule

// >>> test/dual_clock_block_ram_fifo_test.sv
// Self-checking testbench for the block memory FIFO
`timescale 1ns/10ps
`include "ebm_fifo_params.svh"

module dual_clock_block_ram_fifo_test;
    import ebm_fifo_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic fifo_select = 1'b0;
    write_mode_type write_mode = WM_NORMAL;
    logic latch_reset_sync = 1'b1;
    logic [3:0] full_thr = 4'h4;
    logic [3:0] afull_thr = 4'h3;
    logic [3:0] aempty_thr = 4'h1;
    logic wclk, wce, we, rclk, rd_ce, rd_stb, full_flag, almost_full_flag;
    logic empty_flag, almost_empty_flag, fifo_clear = 1'b0, rewind = 1'b0;
    logic clr_a = 1'b0, clr_b = 1'b0, chip_rst_n = 1'b1;
    logic [3:0] addr_a, addr_b;
    logic [7:0] wdata_a, dout_a, dout_b;
    int n_errors = 0;
    int n_tests = 0;

    // ****************************************
    // Clock, design and user model
    // ****************************************
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end

    dual_clock_block_ram_fifo dual_clock_block_ram_fifo_inst (
        .clk_sys(clk_sys), .rst(rst), .fifo_select(fifo_select),
        .write_mode(write_mode), .latch_reset_sync(latch_reset_sync),
        .full_threshold(full_thr), .almost_full_threshold(afull_thr),
        .almost_empty_threshold(aempty_thr), .write_side_clock(wclk),
        .write_clock_enable(wce), .write_enable(we), .addr_a(addr_a),
        .wdata_a(wdata_a), .dout_a(dout_a), .read_side_clock(rclk),
        .read_clock_enable(rd_ce), .read_strobe(rd_stb), .addr_b(addr_b),
        .dout_b(dout_b), .fifo_clear(fifo_clear),
        .read_pointer_rewind(rewind), .full_flag(full_flag),
        .almost_full_flag(almost_full_flag), .empty_flag(empty_flag),
        .almost_empty_flag(almost_empty_flag),
        .port_a_latch_clear(clr_a), .port_b_latch_clear(clr_b),
        .chip_wide_reset_n(chip_rst_n));

    ebm_user_model ebm_user_model_inst (
        .clk_sys(clk_sys), .write_side_clock(wclk),
        .write_clock_enable(wce), .write_enable(we), .addr_a(addr_a),
        .wdata_a(wdata_a), .read_side_clock(rclk),
        .read_clock_enable(rd_ce), .read_strobe(rd_stb), .addr_b(addr_b));

    // ****************************************
    // Shared helpers
    // ****************************************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask

    // Flags packed as full, almost full, empty, almost empty
    function automatic logic [7:0] flags();
        return {4'h0, full_flag, almost_full_flag, empty_flag,
                almost_empty_flag};
    endfunction

    task automatic end_sim();
        if (n_errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    // RAM mode: output behaviour on port A writes in each mode
    task automatic ram_modes();
        write_mode = WM_THROUGH;
        ebm_user_model_inst.wr(4'h3, 8'h11, 1'b1);
        chk(dout_a, 8'h11);
        write_mode = WM_NORMAL;
        ebm_user_model_inst.wr(4'h3, 8'h22, 1'b1);
        chk(dout_a, 8'h11);
        write_mode = WM_READ_FIRST;
        ebm_user_model_inst.wr(4'h3, 8'h33, 1'b1);
        chk(dout_a, 8'h22);
        ebm_user_model_inst.rd(4'h3, 1'b1);
        chk(dout_b, 8'h33);
        write_mode = WM_NORMAL;
        ebm_user_model_inst.wr(4'h3, 8'h44, 1'b0);
        chk(dout_a, 8'h33);
    endtask

    // FIFO: fill past full, then drain past empty, then rewind
    task automatic fifo_flow();
        int lvl;
        fifo_select = 1'b1;
        write_mode = WM_THROUGH;
        pulse_clear();
        for (int i = 0; i < 5; i++) begin
            ebm_user_model_inst.wr(4'h0, 8'ha0 + 8'(i), 1'b1);
            lvl = (i < 4) ? i + 1 : 4;
            // Empty side stays stale: no read clock edge yet
            chk(flags(), {4'h0, lvl >= 4, lvl >= 3, 2'b11});
        end
        chk(dout_a, 8'ha3);
        ebm_user_model_inst.rd(4'h0, 1'b0);
        chk(flags(), 8'h0c);
        for (int i = 0; i < 5; i++) begin
            ebm_user_model_inst.rd(4'h0, 1'b1);
            lvl = (i < 4) ? 3 - i : 0;
            chk(dout_b, 8'ha0 + 8'(i < 4 ? i : 3));
            chk(flags(), {6'h03, lvl == 0, lvl <= 1});
        end
        @(negedge clk_sys);
        rewind = 1'b1;
        @(negedge clk_sys);
        rewind = 1'b0;
        ebm_user_model_inst.rd(4'h0, 1'b1);
        chk(dout_b, 8'ha0);
    endtask

    // Latch clears: each port alone, async blanking, then chip-wide
    task automatic latch_clears();
        @(negedge clk_sys);
        clr_a = 1'b1;
        @(negedge clk_sys);
        chk(dout_a, 8'h00);
        chk(dout_b, 8'ha0);
        clr_a = 1'b0;
        latch_reset_sync = 1'b0;
        clr_b = 1'b1;
        #1 chk(dout_b, 8'h00);
        @(negedge clk_sys);
        clr_b = 1'b0;
        ebm_user_model_inst.wr(4'h0, 8'h5a, 1'b1);
        ebm_user_model_inst.rd(4'h0, 1'b1);
        chk(dout_b, 8'ha1);
        chk(dout_a, 8'h5a);
        chip_rst_n = 1'b0;
        @(negedge clk_sys);
        chk(dout_a, 8'h00);
        chk(dout_b, 8'h00);
        chip_rst_n = 1'b1;
        pulse_clear();
        chk(flags(), 8'h03);
    endtask

    task automatic pulse_clear();
        @(negedge clk_sys);
        fifo_clear = 1'b1;
        @(negedge clk_sys);
        fifo_clear = 1'b0;
    endtask

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        ram_modes();
        fifo_flow();
        latch_clears();
        end_sim();
    end

    // The run needs about 50 cycles; allow forty times that
    initial begin
        #100000;
        n_errors++;
        end_sim();
    end
endmodule
